// [pkg/iem_pkg.sv]
package iem_pkg;

   // direct register addresses on the management port
   localparam logic [7:0] ADDR_SEL  = 8'h6E;
   localparam logic [7:0] ADDR_OFS  = 8'h6F;
   localparam logic [7:0] ADDR_DATA = 8'hA0;
   localparam logic [7:0] ADDR_STS  = 8'h70;
   localparam logic [7:0] ADDR_CLR  = 8'h71;
   localparam logic [7:0] ADDR_IEN  = 8'h72;
   localparam logic [7:0] ADDR_CFG  = 8'h73;

   // selection byte layout
   localparam int         SEL_SPACE_HI = 7;
   localparam int         SEL_SPACE_LO = 5;
   localparam int         SEL_RD_BIT   = 4;
   localparam int         SEL_PORT_HI  = 3;
   localparam logic [2:0] SPACE_EEE    = 3'h1;
   localparam logic [2:0] SPACE_MIB    = 3'h3;
   localparam logic [3:0] PORT_GLOBAL  = 4'h0;

   // indirect offsets
   localparam logic [7:0] OFS_HOLD_HI = 8'h2E;
   localparam logic [7:0] OFS_HOLD_LO = 8'h2F;
   localparam logic [7:0] OFS_GLB0_HI = 8'h30;
   localparam logic [7:0] OFS_GLB0_LO = 8'h31;
   localparam int         MIB_COUNT   = 8;
   localparam int         MIB_W       = 32;

   // reset values
   localparam logic [7:0]  HOLD_RST    = 8'h27;
   localparam logic [7:0]  HOLD_RSVD   = 8'hFF;
   localparam logic [15:0] GLB0_RST    = 16'h0000;

   // timing
   localparam int UNIT_NS   = 640;
   localparam int CLK_NS    = 40;
   localparam int UNIT_CYC  = (UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CW   = 12;

   // frame sizes
   localparam int          LEN_W     = 11;
   localparam logic [10:0] LEN_MIN   = 11'd64;
   localparam logic [10:0] LEN_1522  = 11'd1522;
   localparam logic [10:0] LEN_1536  = 11'd1536;
   localparam logic [10:0] LEN_1916  = 11'd1916;

   // interrupt status bits
   localparam int STS_HOLD_DONE = 0;
   localparam int STS_MIB_WRAP  = 1;

endpackage

// [pkg/iem_mgmt_if.sv]
`timescale 1ns/1ps
interface iem_mgmt_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       wr;
   logic       rd;
   logic       irq;

   modport dev (
      input  addr,
      input  wdata,
      input  wr,
      input  rd,
      output rdata,
      output irq
   );

   modport host (
      output addr,
      output wdata,
      output wr,
      output rd,
      input  rdata,
      input  irq
   );
endinterface

// [hw/iem_dev.sv]
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// How it works
// - hold transmit for count times 640 ns
// - holdoff count resets to 39
// - software programs larger local/remote recovery time
// - select byte picks space and port
// - holdoff at 0x2E/0x2F, upper byte read-only
// - read select plus offset write fetches byte
// - write select, offset, then data byte
// - port field zero addresses global registers
// - separate counters per port, indirect only
// - counter 0 sums high priority octets
// - counter 1 counts short good frames
// - counter 2 counts short bad frames
// - counter 3 counts long good frames
// - counter 4 counts bad frames over 1522, or every frame over 1916 when size bit 1 is set
// - counter 5 counts bad symbol frames
// - counter 6 counts whole-byte bad CRC
// - counter 7 counts fractional bad CRC
module iem_dev
   import iem_pkg::*;
#(
   parameter int NPORTS     = 2,
   parameter int FIRST_PORT = 3
) (
   // clock and reset
   input  wire logic                             clk_i,
   input  wire logic                             rst_n_i,
   // management port
   iem_mgmt_if.dev                               bus,
   // mac idle exit and transmit hold
   input  wire logic [NPORTS-1:0]                lpi_exit_i,
   output logic      [NPORTS-1:0]                tx_hold_o,
   // received frame reports
   input  wire logic [NPORTS-1:0]                frame_end_i,
   input  wire logic [NPORTS-1:0][LEN_W-1:0]     frame_len_i,
   input  wire logic [NPORTS-1:0]                frame_crc_ok_i,
   input  wire logic [NPORTS-1:0]                frame_sym_err_i,
   input  wire logic [NPORTS-1:0]                frame_odd_i,
   input  wire logic [NPORTS-1:0]                frame_hi_prio_i
);
   localparam int PW = (NPORTS > 1) ? $clog2(NPORTS) : 1;

   if (NPORTS < 1 || FIRST_PORT < 1 || FIRST_PORT + NPORTS > 16) begin : g_chk
      $error("iem_dev: port range does not fit the 4-bit port field");
   end

   logic [7:0]                             sel;
   logic [7:0]                             ofs;
   logic [7:0]                             dbyte;
   logic [7:0]                             rdata;
   logic [15:0]                            glb0;
   logic [NPORTS-1:0][7:0]                 hold_cnt;
   logic [NPORTS-1:0][MIB_COUNT-1:0][MIB_W-1:0] mib;
   logic [MIB_W-1:0]                       snap;
   logic [1:0]                             snap_idx;
   logic [1:0]                             sts;
   logic [1:0]                             ien;
   logic [1:0]                             size_cfg;
   logic [NPORTS-1:0]                      hold_done;
   logic [NPORTS-1:0]                      port_wrap;

   // bus decode
   wire        wr_sel  = bus.wr && (bus.addr == ADDR_SEL);
   wire        wr_ofs  = bus.wr && (bus.addr == ADDR_OFS);
   wire        wr_dat  = bus.wr && (bus.addr == ADDR_DATA);
   wire        wr_clr  = bus.wr && (bus.addr == ADDR_CLR);
   wire        wr_ien  = bus.wr && (bus.addr == ADDR_IEN);
   wire        wr_cfg  = bus.wr && (bus.addr == ADDR_CFG);
   wire        rd_dat  = bus.rd && (bus.addr == ADDR_DATA);

   // selection fields
   wire [2:0]  space   = sel[SEL_SPACE_HI:SEL_SPACE_LO];
   wire        rd_mode = sel[SEL_RD_BIT];
   wire [3:0]  port    = sel[SEL_PORT_HI:0];
   wire        is_glb  = (port == PORT_GLOBAL);
   wire        port_ok = (port >= 4'(FIRST_PORT)) && (port < 4'(FIRST_PORT + NPORTS));
   wire [3:0]  pdiff   = port - 4'(FIRST_PORT);
   wire [PW-1:0] pidx  = pdiff[PW-1:0];

   // offset seen by a fetch: the one being written now
   wire [7:0]  f_ofs   = wr_ofs ? bus.wdata : ofs;
   wire        trig    = wr_ofs && rd_mode;
   wire        eee_sp  = (space == SPACE_EEE);
   wire        mib_sp  = (space == SPACE_MIB);

   // eee byte fetch
   wire [7:0]  glb_byte  = (f_ofs == OFS_GLB0_HI) ? glb0[15:8] :
                           (f_ofs == OFS_GLB0_LO) ? glb0[7:0]  : 8'h00;
   wire [7:0]  port_byte = !port_ok                ? 8'h00 :
                           (f_ofs == OFS_HOLD_HI)  ? HOLD_RSVD :
                           (f_ofs == OFS_HOLD_LO)  ? hold_cnt[pidx] : 8'h00;
   wire [7:0]  eee_byte  = is_glb ? glb_byte : port_byte;

   // mib fetch, counters only through this path
   wire        mib_hit   = port_ok && (f_ofs < 8'(MIB_COUNT));
   wire [MIB_W-1:0] mib_word = mib_hit ? mib[pidx][f_ofs[2:0]] : '0;

   // eee write target
   wire        ind_wr    = wr_dat && !rd_mode && eee_sp;
   wire        wr_hold   = ind_wr && port_ok && (ofs == OFS_HOLD_LO);

   // max legal frame length by size setting
   wire [LEN_W-1:0] len_max = size_cfg[1] ? LEN_1916 :
                              size_cfg[0] ? LEN_1536 : LEN_1522;

   // read mux
   wire [7:0]  rd_mux = (bus.addr == ADDR_SEL)  ? sel :
                        (bus.addr == ADDR_OFS)  ? ofs :
                        (bus.addr == ADDR_DATA) ? dbyte :
                        (bus.addr == ADDR_STS)  ? {6'h00, sts} :
                        (bus.addr == ADDR_IEN)  ? {6'h00, ien} :
                        (bus.addr == ADDR_CFG)  ? {6'h00, size_cfg} : 8'h00;

   assign bus.rdata = rdata;
   assign bus.irq   = |(sts & ien);

   // direct registers and indirect data path
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sel      <= 8'h00;
         ofs      <= 8'h00;
         dbyte    <= 8'h00;
         rdata    <= 8'h00;
         glb0     <= GLB0_RST;
         snap     <= '0;
         snap_idx <= 2'h0;
         ien      <= 2'h0;
         size_cfg <= 2'h0;
      end else begin
         rdata <= bus.rd ? rd_mux : 8'h00;
         if (wr_sel) begin
            sel <= bus.wdata;
         end
         if (wr_ofs) begin
            ofs <= bus.wdata;
         end
         if (wr_ien) begin
            ien <= bus.wdata[1:0];
         end
         if (wr_cfg) begin
            size_cfg <= bus.wdata[1:0];
         end
         if (trig && eee_sp) begin
            dbyte <= eee_byte;
         end else if (trig && mib_sp) begin
            snap     <= mib_word;
            dbyte    <= mib_word[31:24];
            snap_idx <= 2'h1;
         end else if (rd_dat && mib_sp) begin
            dbyte    <= snap[8*(3-snap_idx) +: 8];
            snap_idx <= snap_idx + 2'h1;
         end else if (wr_dat) begin
            dbyte <= bus.wdata;
         end
         if (ind_wr && is_glb && (ofs == OFS_GLB0_HI)) begin
            glb0[15:8] <= bus.wdata;
         end
         if (ind_wr && is_glb && (ofs == OFS_GLB0_LO)) begin
            glb0[7:0] <= bus.wdata;
         end
      end
   end

   // sticky status, set wins over clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sts <= 2'h0;
      end else begin
         sts[STS_HOLD_DONE] <= (sts[STS_HOLD_DONE] && !(wr_clr && bus.wdata[STS_HOLD_DONE]))
                               || (|hold_done);
         sts[STS_MIB_WRAP]  <= (sts[STS_MIB_WRAP] && !(wr_clr && bus.wdata[STS_MIB_WRAP]))
                               || (|port_wrap);
      end
   end

   // per port holdoff timer and counters
   for (genvar p = 0; p < NPORTS; p++) begin : g_port
      logic [HOLD_CW-1:0]         tmr;
      logic                       hold;
      logic [MIB_COUNT-1:0][MIB_W-1:0] inc;
      logic [MIB_COUNT-1:0]       wrap;

      wire [HOLD_CW-1:0] hold_cyc = HOLD_CW'(hold_cnt[p]) * HOLD_CW'(UNIT_CYC);
      wire my_wr = wr_hold && (pidx == PW'(p));

      // frame classification
      wire [LEN_W-1:0] len   = frame_len_i[p];
      wire crc_ok  = frame_crc_ok_i[p];
      wire sym     = frame_sym_err_i[p];
      wire odd     = frame_odd_i[p];
      wire short_f = len < LEN_MIN;
      wire legal   = !short_f && (len <= len_max);
      wire any_err = !crc_ok || sym || odd;

      always_comb begin
         inc    = '0;
         inc[0] = frame_hi_prio_i[p] ? MIB_W'(len) : '0;
         inc[1] = MIB_W'(short_f && !any_err);
         inc[2] = MIB_W'(short_f && any_err);
         inc[3] = MIB_W'((len > len_max) && crc_ok && !sym && !odd);
         inc[4] = size_cfg[1] ? MIB_W'(len > LEN_1916) :
                                MIB_W'((len > LEN_1522) && any_err);
         inc[5] = MIB_W'(legal && sym);
         inc[6] = MIB_W'(legal && !sym && !odd && !crc_ok);
         inc[7] = MIB_W'(legal && !sym && odd && !crc_ok);
      end

      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            hold_cnt[p] <= HOLD_RST;
            tmr         <= '0;
            hold        <= 1'b0;
            hold_done[p] <= 1'b0;
         end else begin
            if (my_wr) begin
               hold_cnt[p] <= bus.wdata;
            end
            hold_done[p] <= hold && (tmr == '0);
            if (lpi_exit_i[p] && (hold_cyc != '0)) begin
               hold <= 1'b1;
               tmr  <= hold_cyc - HOLD_CW'(1);
            end else if (tmr != '0) begin
               tmr <= tmr - HOLD_CW'(1);
            end else begin
               hold <= 1'b0;
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            mib[p]       <= '0;
            port_wrap[p] <= 1'b0;
         end else begin
            port_wrap[p] <= frame_end_i[p] && (|wrap);
            if (frame_end_i[p]) begin
               for (int k = 0; k < MIB_COUNT; k++) begin
                  mib[p][k] <= mib[p][k] + inc[k];
               end
            end
         end
      end

      for (genvar k = 0; k < MIB_COUNT; k++) begin : g_wrap
         wire [MIB_W:0] sum = {1'b0, mib[p][k]} + {1'b0, inc[k]};
         assign wrap[k] = sum[MIB_W];
      end

      assign tx_hold_o[p] = hold;
   end
endmodule

// [hw/iem_host.sv]
`timescale 1ns/1ps
module iem_host
   import iem_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // management port
   iem_mgmt_if.host        bus,
   // command side
   input  wire logic       cmd_valid_i,
   input  wire logic       cmd_write_i,
   input  wire logic [2:0] cmd_space_i,
   input  wire logic [3:0] cmd_port_i,
   input  wire logic [7:0] cmd_offset_i,
   input  wire logic [7:0] cmd_wdata_i,
   output logic            cmd_ready_o,
   // response side
   output logic            resp_valid_o,
   output logic [7:0]      resp_data_o,
   output logic            irq_o
);
   typedef enum logic [2:0] {
      IEMH_IDLE = 3'b000,
      IEMH_SEL  = 3'b001,
      IEMH_OFS  = 3'b011,
      IEMH_DAT  = 3'b010,
      IEMH_CAP  = 3'b110
   } iem_hstate_t;

   iem_hstate_t state;
   logic        is_wr;
   logic [7:0]  ofs;
   logic [7:0]  data;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;

   assign cmd_ready_o = (state == IEMH_IDLE);
   assign bus.addr    = addr;
   assign bus.wdata   = wdata;
   assign bus.wr      = wr;
   assign bus.rd      = rd;
   assign irq_o       = bus.irq;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state        <= IEMH_IDLE;
         is_wr        <= 1'b0;
         ofs          <= 8'h00;
         data         <= 8'h00;
         addr         <= 8'h00;
         wdata        <= 8'h00;
         wr           <= 1'b0;
         rd           <= 1'b0;
         resp_valid_o <= 1'b0;
         resp_data_o  <= 8'h00;
      end else begin
         resp_valid_o <= 1'b0;
         unique case (state)
            IEMH_IDLE: begin
               if (cmd_valid_i) begin
                  is_wr <= cmd_write_i;
                  ofs   <= cmd_offset_i;
                  data  <= cmd_wdata_i;
                  addr  <= ADDR_SEL;
                  wdata <= {cmd_space_i, !cmd_write_i, cmd_port_i};
                  wr    <= 1'b1;
                  state <= IEMH_SEL;
               end
            end
            IEMH_SEL: begin
               addr  <= ADDR_OFS;
               wdata <= ofs;
               state <= IEMH_OFS;
            end
            IEMH_OFS: begin
               addr  <= ADDR_DATA;
               wdata <= data;
               wr    <= is_wr;
               rd    <= !is_wr;
               state <= IEMH_DAT;
            end
            IEMH_DAT: begin
               wr <= 1'b0;
               rd <= 1'b0;
               if (is_wr) begin
                  resp_valid_o <= 1'b1;
                  state        <= IEMH_IDLE;
               end else begin
                  state <= IEMH_CAP;
               end
            end
            IEMH_CAP: begin
               resp_data_o  <= bus.rdata;
               resp_valid_o <= 1'b1;
               state        <= IEMH_IDLE;
            end
            default: begin
               state <= IEMH_IDLE;
            end
         endcase
      end
   end
endmodule

// [dv/iem_assertions.sv]
`timescale 1ns/1ps
module iem_assertions
   import iem_pkg::*;
(
   // clock and reset
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   // management port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic       irq
);
   logic written;
   wire  sel_w = wr && addr == ADDR_SEL;
   wire  ofs_w = wr && addr == ADDR_OFS;
   wire  sel_p = sel_w && wdata[7:4] == 4'h3 && wdata[3:0] inside {4'h3, 4'h4};

   // any indirect data write since reset
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         written <= 1'b0;
      end else if (wr && addr == ADDR_DATA) begin
         written <= 1'b1;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read answer");
   strobe_excl_a: assert property (!(wr && rd))
      else $error("both strobes high");
   read_pulse_a: assert property (rd |=> !rd)
      else $error("read strobe too long");
   sel_order_a: assert property (sel_w |=> ofs_w)
      else $error("no offset write after selection");
   ofs_order_a: assert property (ofs_w |=> addr == ADDR_DATA && (wr ^ rd))
      else $error("no data access after offset");
   hold_rsvd_a: assert property ($past(sel_p, 2) && $past(ofs_w && wdata == OFS_HOLD_HI)
      && rd |=> rdata == HOLD_RSVD)
      else $error("reserved byte wrong");
   glob_sel_a: assert property ($past(sel_w && wdata == 8'h30, 2)
      && $past(ofs_w && wdata == OFS_HOLD_LO) && rd |=> rdata == 8'h00)
      else $error("global space returned port data");
   hold_reset_a: assert property ($past(sel_p, 2) && $past(ofs_w && wdata == OFS_HOLD_LO)
      && rd && !written |=> rdata == HOLD_RST)
      else $error("holdoff reset value wrong");
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import iem_pkg::*;
   typedef struct packed {
      logic [7:0]  cfg;
      logic [10:0] len;
      logic        ok;
      logic        sym;
      logic        odd;
      logic        hi;
      logic [3:0]  idx;
   } iem_row_t;
   // cfg, length, crc ok, symbol error, odd, high priority, counter hit (8 none)
   localparam iem_row_t ROWS [14] = '{
      '{0, 40, 1, 0, 0, 0, 1}, '{0, 63, 1, 0, 0, 0, 1}, '{0, 40, 0, 0, 0, 0, 2},
      '{0, 1600, 1, 0, 0, 0, 3}, '{0, 1530, 1, 0, 0, 0, 3}, '{1, 1530, 1, 0, 0, 0, 8},
      '{0, 1600, 0, 0, 0, 1, 4}, '{2, 2000, 0, 0, 0, 0, 4}, '{0, 100, 1, 1, 0, 0, 5},
      '{0, 64, 0, 0, 0, 0, 6}, '{0, 1522, 0, 0, 1, 0, 7}, '{0, 200, 1, 0, 0, 1, 8},
      '{0, 1522, 1, 0, 0, 0, 8}, '{3, 1600, 1, 0, 0, 0, 8}};
   logic                  clk_i = 1'b0;
   logic                  rst_n_i = 1'b0;
   logic                  cmd_valid = 1'b0;
   logic                  cmd_write = 1'b0;
   logic [3:0]            cmd_port = 4'h0;
   logic [7:0]            cmd_ofs = 8'h00;
   logic [7:0]            cmd_wdata = 8'h00;
   logic                  cmd_ready;
   logic                  resp_valid;
   logic [7:0]            resp_data;
   logic                  irq_h;
   logic [1:0]            lpi = 2'b00;
   logic [1:0]            hold_a;
   logic [1:0]            hold_b;
   logic [1:0]            f_end = 2'b00;
   logic [1:0][LEN_W-1:0] f_len = '0;
   logic [1:0]            f_ok = 2'b00;
   logic [1:0]            f_sym = 2'b00;
   logic [1:0]            f_odd = 2'b00;
   logic [1:0]            f_hi = 2'b00;
   int                    n_errors = 0;
   int                    comparisons = 0;
   int                    cyc = 0;

   iem_mgmt_if bus_a();
   iem_mgmt_if bus_b();
   iem_dev i_iem_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_a), .lpi_exit_i(lpi),
      .tx_hold_o(hold_a), .frame_end_i(f_end), .frame_len_i(f_len), .frame_crc_ok_i(f_ok),
      .frame_sym_err_i(f_sym), .frame_odd_i(f_odd), .frame_hi_prio_i(f_hi));
   iem_dev i_iem_dev_b (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_b), .lpi_exit_i(lpi),
      .tx_hold_o(hold_b), .frame_end_i(f_end), .frame_len_i(f_len), .frame_crc_ok_i(f_ok),
      .frame_sym_err_i(f_sym), .frame_odd_i(f_odd), .frame_hi_prio_i(f_hi));
   iem_host i_iem_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_a), .cmd_valid_i(cmd_valid),
      .cmd_write_i(cmd_write), .cmd_space_i(SPACE_EEE), .cmd_port_i(cmd_port),
      .cmd_offset_i(cmd_ofs), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready),
      .resp_valid_o(resp_valid), .resp_data_o(resp_data), .irq_o(irq_h));
   iem_assertions i_iem_assertions (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr(bus_a.addr),
      .wdata(bus_a.wdata), .rdata(bus_a.rdata), .wr(bus_a.wr), .rd(bus_a.rd), .irq(bus_a.irq));

   initial begin
      forever #20 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      if (n_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         $display("Error at %0t: run did not finish", $time);
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one command through the host, with its fixed answer latency
   task automatic hcmd(input logic w, input logic [3:0] p, input logic [7:0] o,
                       input logic [7:0] d, output logic [7:0] q);
      int i;
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_port  <= p;
      cmd_ofs   <= o;
      cmd_wdata <= d;
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      i = 0;
      do begin
         @(posedge clk_i);
         #1;
         i++;
      end while (!resp_valid && i < 8);
      chk(i, w ? 3 : 4);
      chk(cmd_ready, 1'b1);
      q = resp_data;
   endtask

   task automatic hrd(input logic [3:0] p, input logic [7:0] o, input logic [7:0] exp);
      logic [7:0] q;
      hcmd(1'b0, p, o, 8'h00, q);
      chk(q, exp);
   endtask

   task automatic bw(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_b.addr  <= a;
      bus_b.wdata <= d;
      bus_b.wr    <= 1'b1;
      @(posedge clk_i);
      bus_b.wr    <= 1'b0;
   endtask

   task automatic br(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk_i);
      bus_b.addr <= a;
      bus_b.rd   <= 1'b1;
      @(posedge clk_i);
      bus_b.rd   <= 1'b0;
      #1;
      q = bus_b.rdata;
   endtask

   // counter snapshot, most significant byte first
   task automatic rmib(input logic [3:0] p, input logic [7:0] k, output logic [31:0] v);
      logic [7:0] b;
      bw(ADDR_SEL, {SPACE_MIB, 1'b1, p});
      bw(ADDR_OFS, k);
      repeat (4) begin
         br(ADDR_DATA, b);
         v = {v[23:0], b};
      end
   endtask

   initial begin
      logic [7:0]  q;
      logic [31:0] v;
      logic [31:0] exp [9];
      int          h0;
      int          h1;
      int          hb;
      exp = '{default: 0};
      bus_b.addr = 8'h00;
      bus_b.wdata = 8'h00;
      bus_b.wr = 1'b0;
      bus_b.rd = 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (ROWS[r]) begin
         bw(ADDR_CFG, ROWS[r].cfg);
         @(posedge clk_i);
         f_end[0] <= 1'b1;
         f_len[0] <= ROWS[r].len;
         f_ok[0]  <= ROWS[r].ok;
         f_sym[0] <= ROWS[r].sym;
         f_odd[0] <= ROWS[r].odd;
         f_hi[0]  <= ROWS[r].hi;
         @(posedge clk_i);
         f_end[0] <= 1'b0;
         exp[ROWS[r].idx]++;
         if (ROWS[r].hi) exp[0] += 32'(ROWS[r].len);
      end
      for (int k = 0; k < MIB_COUNT; k++) begin
         rmib(4'h3, 8'(k), v);
         chk(v, exp[k]);
      end
      rmib(4'h4, 8'h01, v);
      chk(v, 32'h0);
      hrd(4'h3, OFS_HOLD_LO, HOLD_RST);
      hrd(4'h4, OFS_HOLD_HI, HOLD_RSVD);
      hrd(PORT_GLOBAL, OFS_HOLD_LO, 8'h00);
      hcmd(1'b1, 4'h3, OFS_HOLD_LO, 8'h02, q);
      hcmd(1'b1, 4'h3, OFS_HOLD_HI, 8'h55, q);
      hcmd(1'b1, PORT_GLOBAL, OFS_GLB0_LO, 8'h5A, q);
      hrd(4'h3, OFS_HOLD_LO, 8'h02);
      hrd(4'h3, OFS_HOLD_HI, HOLD_RSVD);
      hrd(PORT_GLOBAL, OFS_GLB0_LO, 8'h5A);
      hrd(4'h4, OFS_HOLD_LO, HOLD_RST);
      bw(ADDR_IEN, 8'h01);
      @(posedge clk_i);
      lpi <= 2'b11;
      @(posedge clk_i);
      lpi <= 2'b00;
      h0 = 0;
      h1 = 0;
      hb = 0;
      repeat (700) begin
         #1;
         h0 += int'(hold_a[0]);
         h1 += int'(hold_a[1]);
         hb += int'(hold_b[0]);
         @(posedge clk_i);
      end
      chk(h0, 2 * 16);
      chk(h1, 39 * 16);
      chk(hb, 39 * 16);
      chk({hold_a, hold_b}, 4'h0);
      #1;
      chk(bus_b.irq, 1'b1);
      br(ADDR_STS, q);
      chk(q, 8'h01);
      bw(ADDR_IEN, 8'h00);
      #1;
      chk(bus_b.irq, 1'b0);
      bw(ADDR_IEN, 8'h01);
      #1;
      chk(bus_b.irq, 1'b1);
      bw(ADDR_STS, 8'hFF);
      bw(ADDR_CLR, 8'h01);
      br(ADDR_STS, q);
      chk(q, 8'h00);
      chk(bus_b.irq, 1'b0);
      br(ADDR_CLR, q);
      chk(q, 8'h00);
      br(ADDR_SEL, q);
      chk(q, {SPACE_MIB, 1'b1, 4'h4});
      br(ADDR_OFS, q);
      chk(q, 8'h01);
      br(ADDR_IEN, q);
      chk(q, 8'h01);
      br(8'h55, q);
      chk(q, 8'h00);
      chk(irq_h, 1'b0);
      end_of_test();
   end
endmodule
